//--- pebc_pkg.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
package pebc_pkg;

    // Bus widths and page geometry
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PAGE_OFS_W  = 6;
    localparam int unsigned PAGE_W      = ADDR_W - PAGE_OFS_W;
    localparam int unsigned PAGE_BYTES  = 64;
    localparam int unsigned PCNT_W      = 7;
    localparam int unsigned TMR_W       = 24;

    // Clock
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Times as printed, in their own units
    localparam int unsigned WR_PULSE_NS    = 150;
    localparam int unsigned GLITCH_NS      = 20;
    localparam int unsigned READ_ACCESS_NS = 300;
    localparam int unsigned BLC_MIN_NS     = 150;
    localparam int unsigned BLC_MAX_US     = 100;
    localparam int unsigned LOCKOUT_MAX_MS = 10;
    localparam int unsigned PROG_MAX_MS    = 10;

    // Least times round up
    localparam int unsigned WR_PULSE_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_ACCESS_CYC =
        (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLC_MIN_CYC     = (BLC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int unsigned BLC_MAX_CYC     = (BLC_MAX_US * 1000) / CLK_PERIOD_NS;
    // Device maxima that the host must outwait round up
    localparam int unsigned LOCKOUT_CYC     =
        (LOCKOUT_MAX_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_CYC        =
        (PROG_MAX_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host margins
    localparam int unsigned SYNC_LAT_CYC      = 2;
    localparam int unsigned WINDOW_MARGIN_CYC = 8;

    // Controller states
    typedef enum logic [3:0] {
        ST_INIT_LOAD,
        ST_INIT_WAIT,
        ST_IDLE,
        ST_RD_ACCESS,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_PAGE_OPEN,
        ST_PROG_WAIT
    } pebc_state_t;

endpackage : pebc_pkg

`default_nettype wire

//--- pebc_timer.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pebc_timer
    import pebc_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Load
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] load_val,
    // Status
    output logic      [TMR_W-1:0] remain,
    output logic                  expired
);

    logic [TMR_W-1:0] remain_ff;
    logic [TMR_W-1:0] nxt_remain;

    // Down count, reload wins over counting
    always_comb begin
        nxt_remain = remain_ff;
        if (load) begin
            nxt_remain = load_val;
        end else if (remain_ff != '0) begin
            nxt_remain = remain_ff - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            remain_ff <= '0;
        end else begin
            remain_ff <= nxt_remain;
        end
    end

    assign remain  = remain_ff;
    assign expired = (remain_ff == '0);

    // A load is seen exactly one cycle later
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_timer_reload: assert property (load |=> remain_ff == $past(load_val)) // R8
        else $error("timer did not take its load value");

endmodule : pebc_timer

`default_nettype wire

//--- pebc_host.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Read: select and output enable low, strobe high; host keeps its data drive off.
// [R2] Strobe write: select low, output enable high, write strobe pulsed low, host drives data.
// [R3] Select-controlled write exists in the device; this host always uses strobe writes.
// [R4] Address held through the pulse; data held until after the strobe rises.
// [R5] Select high is standby; host parks select high and releases the bus when idle.
// [R6] Strobe and output enable both high means no access and no drive.
// [R7] Strobe pulses under 20 ns are ignored; host pulses are always far longer.
// [R8] Device restarts the load window timer at every strobe rising edge.
// [R9] Window expiry starts the device's program cycle for the loaded bytes.
// [R10] A strobe fall inside the window extends the page; host keeps loads inside it.
// [R11] Host spaces byte loads at least 0.15 us and at most 100 us apart.
// [R12] No writes during the 5 to 10 ms lockout after power-up.
// [R13] Program cycle finishes within 10 ms; host waits it out before the next access.
// [R14] One to sixty-four loads per page before a single program cycle.
module pebc_host
    import pebc_pkg::*;
#(
    parameter int unsigned BLC_MAX_CYCLES = BLC_MAX_CYC,
    parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_CYC,
    parameter int unsigned PROG_CYCLES    = PROG_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Command port
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    output logic                   cmd_ready,
    // Read answer and status
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid,
    output logic                   busy,
    // Device pins
    output logic                   chip_select_n,
    output logic                   write_strobe_n,
    output logic                   output_drive_enable_n,
    output logic      [ADDR_W-1:0] word_address,
    output logic      [DATA_W-1:0] data_pins_o,
    output logic                   data_pins_oe,
    input  wire logic [DATA_W-1:0] data_pins_i
);

    ////////////////////////////////////////////////////////////////////////////
    pebc_state_t       state_ff,  nxt_state;
    logic              ce_n_ff,   nxt_ce_n;
    logic              we_n_ff,   nxt_we_n;
    logic              oe_n_ff,   nxt_oe_n;
    logic [ADDR_W-1:0] addr_ff,   nxt_addr;
    logic [DATA_W-1:0] dout_ff,   nxt_dout;
    logic              doe_ff,    nxt_doe;
    logic [DATA_W-1:0] rdata_ff,  nxt_rdata;
    logic              rvalid_ff, nxt_rvalid;
    logic [PAGE_W-1:0] page_ff,   nxt_page;
    logic [PCNT_W-1:0] pcnt_ff,   nxt_pcnt;
    logic [DATA_W-1:0] din_meta_ff;
    logic [DATA_W-1:0] din_sync_ff;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_val;
    logic [TMR_W-1:0]  tmr_remain;
    logic              tmr_expired;
    logic              page_ok;
    logic              take;

    // Shared timer for lockout, access, pulse, window and program wait
    pebc_timer u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .remain   (tmr_remain),
        .expired  (tmr_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data synchroniser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            din_meta_ff <= '0;
            din_sync_ff <= '0;
        end else begin
            din_meta_ff <= data_pins_i;
            din_sync_ff <= din_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next byte may join the open page only while the window has margin
    assign page_ok = (state_ff == ST_PAGE_OPEN) && cmd_write
                     && (cmd_addr[ADDR_W-1:PAGE_OFS_W] == page_ff)
                     && (pcnt_ff < PCNT_W'(PAGE_BYTES))                    // R14
                     && (tmr_remain > TMR_W'(WINDOW_MARGIN_CYC));          // R10
    assign cmd_ready = (state_ff == ST_IDLE) || page_ok;
    assign take      = cmd_valid && cmd_ready;

    // Sequencer and pin drive
    always_comb begin
        nxt_state  = state_ff;
        nxt_ce_n   = ce_n_ff;
        nxt_we_n   = we_n_ff;
        nxt_oe_n   = oe_n_ff;
        nxt_addr   = addr_ff;
        nxt_dout   = dout_ff;
        nxt_doe    = doe_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_page   = page_ff;
        nxt_pcnt   = pcnt_ff;
        tmr_load   = 1'b0;
        tmr_val    = '0;
        unique case (state_ff)
            ST_INIT_LOAD: begin
                tmr_load  = 1'b1;
                tmr_val   = TMR_W'(LOCKOUT_CYCLES);                        // R12
                nxt_state = ST_INIT_WAIT;
            end
            ST_INIT_WAIT: begin
                if (tmr_expired) begin
                    nxt_state = ST_IDLE;                                   // R12
                end
            end
            ST_IDLE: begin
                if (take && cmd_write) begin
                    nxt_ce_n  = 1'b0;                                      // R2
                    nxt_oe_n  = 1'b1;
                    nxt_addr  = cmd_addr;
                    nxt_dout  = cmd_wdata;
                    nxt_doe   = 1'b1;
                    nxt_page  = cmd_addr[ADDR_W-1:PAGE_OFS_W];
                    nxt_pcnt  = PCNT_W'(1);
                    nxt_state = ST_WR_SETUP;
                end else if (take) begin
                    nxt_ce_n  = 1'b0;                                      // R1
                    nxt_oe_n  = 1'b0;
                    nxt_addr  = cmd_addr;
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(READ_ACCESS_CYC + SYNC_LAT_CYC);
                    nxt_state = ST_RD_ACCESS;
                end
            end
            ST_RD_ACCESS: begin
                if (tmr_expired) begin
                    nxt_rdata  = din_sync_ff;                              // R1
                    nxt_rvalid = 1'b1;
                    nxt_ce_n   = 1'b1;                                     // R5
                    nxt_oe_n   = 1'b1;                                     // R6
                    nxt_state  = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                nxt_we_n  = 1'b0;                                          // R2
                tmr_load  = 1'b1;
                tmr_val   = TMR_W'(WR_PULSE_CYC - 1);                      // R7
                nxt_state = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                if (tmr_expired) begin
                    nxt_we_n  = 1'b1;                                      // R4
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(BLC_MAX_CYCLES);                    // R8
                    nxt_state = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                nxt_ce_n  = 1'b1;                                          // R3 R4
                nxt_doe   = 1'b0;
                nxt_state = ST_PAGE_OPEN;
            end
            ST_PAGE_OPEN: begin
                if (take) begin
                    nxt_ce_n  = 1'b0;                                      // R10
                    nxt_addr  = cmd_addr;
                    nxt_dout  = cmd_wdata;
                    nxt_doe   = 1'b1;
                    nxt_pcnt  = pcnt_ff + 1'b1;                            // R14
                    nxt_state = ST_WR_SETUP;                               // R11
                end else if (tmr_remain <= TMR_W'(WINDOW_MARGIN_CYC)) begin
                    tmr_load  = 1'b1;                                      // R9
                    tmr_val   = TMR_W'(BLC_MAX_CYCLES + PROG_CYCLES);      // R13
                    nxt_state = ST_PROG_WAIT;
                end
            end
            ST_PROG_WAIT: begin
                if (tmr_expired) begin
                    nxt_pcnt  = '0;
                    nxt_state = ST_IDLE;                                   // R13
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_INIT_LOAD;
            ce_n_ff   <= 1'b1;
            we_n_ff   <= 1'b1;
            oe_n_ff   <= 1'b1;
            addr_ff   <= '0;
            dout_ff   <= '0;
            doe_ff    <= 1'b0;
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
            page_ff   <= '0;
            pcnt_ff   <= '0;
        end else begin
            state_ff  <= nxt_state;
            ce_n_ff   <= nxt_ce_n;
            we_n_ff   <= nxt_we_n;
            oe_n_ff   <= nxt_oe_n;
            addr_ff   <= nxt_addr;
            dout_ff   <= nxt_dout;
            doe_ff    <= nxt_doe;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            page_ff   <= nxt_page;
            pcnt_ff   <= nxt_pcnt;
        end
    end

    // Outputs
    assign chip_select_n         = ce_n_ff;
    assign write_strobe_n        = we_n_ff;
    assign output_drive_enable_n = oe_n_ff;
    assign word_address          = addr_ff;
    assign data_pins_o           = dout_ff;
    assign data_pins_oe          = doe_ff;
    assign rd_data               = rdata_ff;
    assign rd_valid              = rvalid_ff;
    assign busy                  = (state_ff != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counters watched by the checks
    logic [31:0] since_rst_cnt;
    logic [31:0] low_cnt;
    logic [31:0] since_fall_cnt;
    logic [31:0] since_rise_cnt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since_rst_cnt  <= '0;
            low_cnt        <= '0;
            since_fall_cnt <= 32'h0000FFFF;
            since_rise_cnt <= '0;
        end else begin
            since_rst_cnt  <= (since_rst_cnt == 32'hFFFFFFFF) ? since_rst_cnt
                                                              : since_rst_cnt + 1'b1;
            low_cnt        <= we_n_ff ? '0 : low_cnt + 1'b1;
            since_fall_cnt <= (ce_n_ff == 1'b0 && nxt_we_n == 1'b0 && we_n_ff) ? '0
                                                              : since_fall_cnt + 1'b1;
            since_rise_cnt <= (nxt_we_n && !we_n_ff) ? '0 : since_rise_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_read_pin_mode: assert property (!oe_n_ff |-> we_n_ff && !ce_n_ff && !doe_ff) // R1
        else $error("read mode pins wrong or data driven");
    chk_write_pin_mode: assert property (!we_n_ff |-> oe_n_ff && !ce_n_ff && doe_ff) // R2
        else $error("write mode pins wrong");
    chk_addr_stable: assert property (!we_n_ff && $past(!we_n_ff) |-> $stable(addr_ff)) // R4
        else $error("address moved during write pulse");
    chk_data_hold: assert property ($rose(we_n_ff) |-> doe_ff && $stable(dout_ff)) // R4
        else $error("data not held at strobe rise");
    chk_idle_standby: assert property (state_ff == ST_IDLE |-> ce_n_ff && !doe_ff) // R5
        else $error("idle bus not in standby");
    chk_no_access_float: assert property (we_n_ff && oe_n_ff && !ce_n_ff
                                          |-> (doe_ff) or (##1 ce_n_ff)) // R6
        else $error("select held without access");
    chk_pulse_width: assert property ($rose(we_n_ff) |-> $past(low_cnt) + 1 >= WR_PULSE_CYC
                                      && $past(low_cnt) + 1 >= GLITCH_CYC) // R7
        else $error("write pulse too short");
    chk_load_spacing: assert property ($fell(we_n_ff) |-> $past(since_fall_cnt) + 1
                                       >= BLC_MIN_CYC) // R11
        else $error("byte loads too close");
    // Only loads that continue an open page must fall inside the window
    chk_window_kept: assert property ($fell(we_n_ff) && pcnt_ff > PCNT_W'(1)
                                      |-> $past(since_rise_cnt) < BLC_MAX_CYCLES) // R10
        else $error("byte load outside window");
    chk_lockout_held: assert property ($fell(we_n_ff) |-> since_rst_cnt >= LOCKOUT_CYCLES) // R12
        else $error("write during power-up lockout");
    chk_prog_quiet: assert property (state_ff == ST_PROG_WAIT |-> ce_n_ff && we_n_ff) // R13
        else $error("bus active during program cycle");
    chk_page_limit: assert property (pcnt_ff <= PCNT_W'(PAGE_BYTES)) // R14
        else $error("too many loads in one page");

    cov_read_done: cover property (state_ff == ST_RD_ACCESS ##1 rd_valid);
    cov_page_two: cover property (state_ff == ST_PAGE_OPEN && take);
    cov_prog_start: cover property (state_ff == ST_PAGE_OPEN ##1 state_ff == ST_PROG_WAIT);

endmodule : pebc_host

`default_nettype wire

//--- pebc_host_unused_check.sv
`default_nettype none
`default_nettype wire

//--- pebc_dev_model.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pebc_dev_model
    import pebc_pkg::*;
#(
    parameter int unsigned ACC_NS   = 300,
    parameter int unsigned LOCK_NS  = 150,
    parameter int unsigned BLC_NS   = 800,
    parameter int unsigned PROG_NS  = 400,
    parameter int unsigned GLIT_NS  = 20,
    parameter int unsigned SPACE_NS = 150
) (
    // Device pins
    input  wire logic              chip_select_n,
    input  wire logic              write_strobe_n,
    input  wire logic              output_drive_enable_n,
    input  wire logic [ADDR_W-1:0] word_address,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    // Observation
    output int                     prog_cnt,
    output int                     viol_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0]     mem  [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]     pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pmask;
    logic [PAGE_W-1:0]     page;
    logic [ADDR_W-1:0]     a_lat;
    logic [DATA_W-1:0]     pat;
    logic                  in_wr;
    logic                  progging;
    realtime               t_fall;
    realtime               t_chg;
    int unsigned           gen;

    // Erased array, empty page buffer
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        pmask = '0;
        pat = 8'h5A;
        in_wr = 1'b0;
        progging = 1'b0;
        t_fall = -1.0e9;
        gen = 0;
        prog_cnt = 0;
        viol_cnt = 0;
    end

    // Later falling edge latches address and stops the window
    always @(negedge write_strobe_n or negedge chip_select_n) begin
        if (!chip_select_n && !write_strobe_n && output_drive_enable_n) begin
            if (pmask != 0 && $realtime - t_fall < SPACE_NS) viol_cnt++;
            a_lat = word_address;
            t_fall = $realtime;
            in_wr = 1'b1;
            gen++;
        end
    end

    // Earlier rising edge latches data; short or early pulses dropped
    always @(posedge write_strobe_n or posedge chip_select_n) begin
        if (in_wr) begin
            in_wr = 1'b0;
            if ($realtime - t_fall >= GLIT_NS && $realtime >= LOCK_NS) begin
                page = a_lat[ADDR_W-1:PAGE_OFS_W];
                pbuf[a_lat[PAGE_OFS_W-1:0]] = data_in;
                pmask[a_lat[PAGE_OFS_W-1:0]] = 1'b1;
                gen++;
                fork
                    arm(gen);
                join_none
            end
        end
    end

    // Window expiry programs only the loaded offsets
    task automatic arm(input int unsigned g);
        #(BLC_NS);
        if (g == gen) begin
            progging = 1'b1;
            #(PROG_NS);
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pmask[i]) mem[{page, i[PAGE_OFS_W-1:0]}] = pbuf[i];
            end
            pmask = '0;
            progging = 1'b0;
            prog_cnt++;
        end
    endtask : arm

    // Drive only with select and output enable low, strobe high
    assign data_oe  = !chip_select_n && !output_drive_enable_n && write_strobe_n;
    assign data_out = pat;
    always @(chip_select_n, output_drive_enable_n, word_address) t_chg = $realtime;
    // Lines keep changing until access time is met, and while programming or released
    always #1 begin
        if (data_oe && !progging && $realtime - t_chg >= ACC_NS) pat <= mem[word_address];
        else pat <= ~pat;
    end
endmodule : pebc_dev_model

`default_nettype wire

//--- tb_top.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_top
    import pebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LOCK = 50;

    logic              sys_clk   = 1'b0;
    logic              rst       = 1'b1;
    logic              cmd_valid = 1'b0;
    logic              cmd_write = 1'b0;
    logic [ADDR_W-1:0] cmd_addr  = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic              cmd_ready;
    logic [DATA_W-1:0] rd_data;
    logic              rd_valid;
    logic              busy;
    logic              chip_select_n;
    logic              write_strobe_n;
    logic              output_drive_enable_n;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] data_pins_o;
    logic              data_pins_oe;
    logic [DATA_W-1:0] dev_o;
    logic              dev_oe;
    wire  [DATA_W-1:0] bus_v = data_pins_oe ? data_pins_o : dev_o;
    int                prog_cnt;
    int                viol_cnt;
    int                error_cnt   = 0;
    int                check_count = 0;
    int                cyc         = 0;

    always #2 sys_clk = ~sys_clk;

    pebc_host #(.BLC_MAX_CYCLES(200), .LOCKOUT_CYCLES(LOCK), .PROG_CYCLES(100)) pebc_host_inst (
        .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_drive_enable_n(output_drive_enable_n), .word_address(word_address),
        .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .data_pins_i(bus_v));

    pebc_dev_model pebc_dev_model_inst (
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_drive_enable_n(output_drive_enable_n), .word_address(word_address),
        .data_in(bus_v), .data_out(dev_o), .data_oe(dev_oe),
        .prog_cnt(prog_cnt), .viol_cnt(viol_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task automatic cmp_val(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : cmp_val

    task automatic cmp_flag(input logic act, input logic exp);
        cmp_val({31'h0, act}, {31'h0, exp});
    endtask : cmp_flag

    task automatic tally_and_finish;
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Pin watch every cycle, plus hang limit
    always @(negedge sys_clk) begin
        cyc++;
        if (!rst) begin
            cmp_flag(data_pins_oe && dev_oe, 1'b0);
            if (!write_strobe_n) cmp_flag(!chip_select_n && output_drive_enable_n, 1'b1);
        end
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command port drivers
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        #1;
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        cmp_flag(cmd_ready, 1'b1);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_flag(busy, 1'b0);
    endtask : wait_idle

    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        issue(1'b0, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_flag(rd_valid, 1'b1);
        cmp_val(rd_data, exp);
    endtask : read_chk

    // Hold a write to the given address pending but invalid; it must stay refused
    task automatic probe_refused(input logic [ADDR_W-1:0] a);
        @(negedge sys_clk);
        cmd_write = 1'b1;
        cmd_addr = a;
        repeat (50) begin
            @(negedge sys_clk);
            #1;
            cmp_flag(cmd_ready, 1'b0);
        end
    endtask : probe_refused

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        int n;
        cmp_flag(chip_select_n && data_pins_oe === 1'b0, 1'b1);
        cmp_flag(busy, 1'b1);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (LOCK / 2) @(negedge sys_clk);
        cmp_flag(cmd_ready, 1'b0);
        wait_idle(n);
        cmp_flag(n + LOCK / 2 >= LOCK, 1'b1);
    endtask : t_reset

    task automatic t_byte;
        int n;
        issue(1'b1, 15'h0123, 8'hA5);
        wait_idle(n);
        cmp_val(prog_cnt, 1);
        read_chk(15'h0123, 8'hA5);
        read_chk(15'h0124, 8'hFF);
    endtask : t_byte

    task automatic t_join;
        int n;
        issue(1'b1, 15'h0045, 8'h11);
        probe_refused(15'h0085);
        issue(1'b1, 15'h0046, 8'h22);
        wait_idle(n);
        cmp_val(prog_cnt, 2);
        read_chk(15'h0045, 8'h11);
        read_chk(15'h0046, 8'h22);
    endtask : t_join

    task automatic t_full;
        int n;
        for (int i = PAGE_BYTES - 1; i >= 0; i--) begin
            issue(1'b1, {9'h1FF, i[5:0]}, i[7:0] ^ 8'h3C);
        end
        probe_refused(15'h7FC0);
        wait_idle(n);
        cmp_val(prog_cnt, 3);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            read_chk({9'h1FF, i[5:0]}, i[7:0] ^ 8'h3C);
        end
        read_chk(15'h7FBF, 8'hFF);
        cmp_val(viol_cnt, 0);
    endtask : t_full

    // Main sequence after 12 cycles of reset
    initial begin
        repeat (11) @(negedge sys_clk);
        t_reset();
        t_byte();
        t_join();
        t_full();
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
